// ### core/occ_clock_ctrl.sv
// oscillator modes, internal sources, trim and switch control
//
// Overview of operation
// - external clock gpio mode needs no start-up delay
// - external clock gpio: clock out pin is port bit6
// - RC mode drives clock out with frequency over four
// - RC gpio mode: clock out pin is port bit6
// - fast source runs 8 MHz, feeds postscaler
// - postscaler gives six frequencies 125 kHz to 4 MHz
// - slow source runs at 31.25 kHz
// - slow source runs if selected, power-up or watchdog
// - clock-out mode: out pin Fosc/4, in pin bit7
// - two-gpio mode: both oscillator pins are port bits
// - trim is signed, zero is calibrated centre
// - uniform trim steps spanning plus minus 12.5 percent
// - trim settles: slow at next slow falling edge, fast 1 ms
// - trim register upper two bits read zero
// - select change moves multiplexer selection after the glitch-free switch sequence
// - select writes accepted whatever clock is running
// - leaving slow code: 4 ms delay, then stable
// - between fast codes no delay, flag stays set
// - switch: current falling edge, hold low, eight edges
// - stable flag read-only at control bit 2
// - select field bits 6 to 4, reset zero
`timescale 1ns/1ps
`default_nettype none

module occ_clock_ctrl #(
    parameter int SWITCH_DLY_CYC = occ_pkg::SWITCH_DLY_CYC  // 4 ms switch delay in cycles
) (
    input wire logic sys_clk,             // 125 MHz system clock
    input wire logic rstn,                // asynchronous reset, active low
    input wire logic [7:0] reg_addr,      // register address
    input wire logic [7:0] reg_wdata,     // register write data
    input wire logic reg_we,              // write strobe
    input wire logic reg_re,              // read strobe
    output logic [7:0] reg_rdata,         // read data, cycle after read strobe
    input wire logic [2:0] osc_mode_cfg,  // nonvolatile oscillator pin mode
    input wire logic pwrt_en,             // power-up timer enabled
    input wire logic wdt_en,              // watchdog timer enabled
    input wire logic sleep_req,           // core asleep, stops clock ticks
    input wire logic clock_in_pin_i,      // clock in pin level
    output logic clock_in_pin_o,          // clock in pin drive value
    output logic clock_in_pin_oe,         // clock in pin driven
    input wire logic clock_out_pin_i,     // clock out pin level
    output logic clock_out_pin_o,         // clock out pin drive value
    output logic clock_out_pin_oe,        // clock out pin driven
    input wire logic port_a_bit6_lat,     // port latch bit 6
    input wire logic port_a_bit6_dir_in,  // port bit 6 direction, 1 input
    input wire logic port_a_bit7_lat,     // port latch bit 7
    input wire logic port_a_bit7_dir_in,  // port bit 7 direction, 1 input
    output logic port_a_bit6_rd,          // port bit 6 pin read value
    output logic port_a_bit7_rd,          // port bit 7 pin read value
    output logic sys_clk_level,           // selected system clock level
    output logic sys_clk_tick,            // one pulse per system clock rise
    output logic osc_ready,               // oscillator usable
    output logic slow_src_run             // slow internal source running
);

    // refuse a switch delay shorter than one cycle
    if (SWITCH_DLY_CYC < 1) begin : g_chk_dly
        $error("switch delay must be at least one cycle");
    end

    localparam int DLY_W = $clog2(SWITCH_DLY_CYC + 1);
    localparam int STEP_W = occ_pkg::FAST_STEP_W;

    // trimmed phase increment of an internal source
    function automatic logic [31:0] occ_trim_inc(
        input logic [31:0] base,
        input logic [31:0] step,
        input logic [5:0] trim
    );
        logic signed [39:0] prod;
        prod = $signed({8'h00, step}) * $signed({{34{trim[5]}}, trim});
        return 32'($signed({8'h00, base}) + prod);
    endfunction : occ_trim_inc

    // level of the clock picked by a select code
    function automatic logic occ_sel_level(
        input logic [2:0] sel,
        input logic fast_lvl,
        input logic [5:0] post,
        input logic slow_lvl
    );
        logic lvl;
        lvl = 1'b0;
        case (sel)
            3'h7: lvl = fast_lvl;
            3'h6: lvl = post[0];
            3'h5: lvl = post[1];
            3'h4: lvl = post[2];
            3'h3: lvl = post[3];
            3'h2: lvl = post[4];
            3'h1: lvl = post[5];
            default: lvl = slow_lvl;
        endcase
        return lvl;
    endfunction : occ_sel_level

    // mode runs from the internal oscillator block
    function automatic logic occ_is_internal(input logic [2:0] mode);
        return (mode == occ_pkg::MODE_INT_CLKOUT) || (mode == occ_pkg::MODE_INT_TWO_GPIO);
    endfunction : occ_is_internal

    // mode hands the clock out pin to port bit 6
    function automatic logic occ_bit6_gpio(input logic [2:0] mode);
        return (mode == occ_pkg::MODE_RC_GPIO) || (mode == occ_pkg::MODE_INT_TWO_GPIO)
            || (mode == occ_pkg::MODE_EXT_CLOCK_GPIO);
    endfunction : occ_bit6_gpio

    logic [2:0] mode_r;
    logic mode_done_r;
    logic osc_ready_r;
    logic [2:0] sel_r;
    logic [5:0] trim_r;
    logic sel_chg_r;
    logic [7:0] rdata_r;
    logic cin_s1_r, cin_s2_r, cout_s1_r, cout_s2_r;
    logic [31:0] fast_acc_r, slow_acc_r;
    logic [5:0] fast_trim_r, slow_trim_r;
    logic [STEP_W-1:0] step_cnt_r;
    logic fast_prev_r, slow_prev_r;
    logic [occ_pkg::POST_W-1:0] post_r;
    logic slow_run_r;
    logic cur_prev_r, req_prev_r;
    occ_pkg::occ_sw_state_t sw_state_r;
    logic [2:0] cur_sel_r;
    logic [3:0] edge_cnt_r;
    logic int_clk_r;
    logic stable_r, pend_r;
    logic [DLY_W-1:0] dly_r;
    logic sys_prev_r;
    logic [occ_pkg::FOSC_DIV_W-1:0] div_r;
    logic sys_lvl_r, tick_r;
    logic cin_o_r, cin_oe_r, cout_o_r, cout_oe_r, rd6_r, rd7_r;

    logic wr_ctrl, wr_trim, sel_start, slow_run;
    logic fast_lvl, slow_lvl, fast_rise, slow_fall;
    logic cur_lvl, req_lvl, cur_fall, req_fall;
    logic sys_lvl, sys_fall, sys_rise;
    logic [2:0] new_sel;

    // register strobes and decoded fields
    always_comb begin
        wr_ctrl = reg_we && (reg_addr == occ_pkg::OFS_CTRL);
        wr_trim = reg_we && (reg_addr == occ_pkg::OFS_TRIM);
        new_sel = reg_wdata[occ_pkg::SEL_LSB +: occ_pkg::SEL_W];
        sel_start = wr_ctrl && (sel_r == occ_pkg::SEL_SLOW) && (new_sel != occ_pkg::SEL_SLOW);
    end

    // pin mode capture
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            mode_r <= occ_pkg::MODE_EXT_CLOCK_GPIO;
            mode_done_r <= 1'b0;
            osc_ready_r <= 1'b0;
        end else begin
            if (!mode_done_r) begin
                mode_r <= osc_mode_cfg;
                mode_done_r <= 1'b1;
            end
            osc_ready_r <= mode_done_r;
        end
    end

    // control and trim registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_r <= occ_pkg::CTRL_RST[occ_pkg::SEL_LSB +: occ_pkg::SEL_W];
            trim_r <= occ_pkg::TRIM_RST;
            sel_chg_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                sel_r <= new_sel;
            end
            if (wr_trim) begin
                trim_r <= reg_wdata[occ_pkg::TRIM_W-1:0];
            end
            sel_chg_r <= wr_ctrl && (new_sel != sel_r);
        end
    end

    // registered read data
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 8'h00;
        end else if (reg_re && reg_addr == occ_pkg::OFS_CTRL) begin
            rdata_r <= {1'b0, sel_r, 1'b0, stable_r, 2'b00};
        end else if (reg_re && reg_addr == occ_pkg::OFS_TRIM) begin
            rdata_r <= {2'b00, trim_r};
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // pin synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cin_s1_r <= 1'b0;
            cin_s2_r <= 1'b0;
            cout_s1_r <= 1'b0;
            cout_s2_r <= 1'b0;
        end else begin
            cin_s1_r <= clock_in_pin_i;
            cin_s2_r <= cin_s1_r;
            cout_s1_r <= clock_out_pin_i;
            cout_s2_r <= cout_s1_r;
        end
    end

    // source levels and run request
    always_comb begin
        slow_run = (sel_r == occ_pkg::SEL_SLOW) || (cur_sel_r == occ_pkg::SEL_SLOW)
            || pwrt_en || wdt_en;
        fast_lvl = fast_acc_r[31];
        slow_lvl = slow_acc_r[31];
        fast_rise = fast_lvl && !fast_prev_r;
        slow_fall = !slow_lvl && slow_prev_r;
    end

    // fast source accumulator
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fast_acc_r <= 32'h0000_0000;
            fast_prev_r <= 1'b0;
        end else begin
            fast_acc_r <= fast_acc_r
                + occ_trim_inc(occ_pkg::FAST_INC, occ_pkg::FAST_STEP, fast_trim_r);
            fast_prev_r <= fast_lvl;
        end
    end

    // slow source, cleared to zero while unused
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slow_acc_r <= 32'h0000_0000;
            slow_prev_r <= 1'b0;
            slow_run_r <= 1'b0;
        end else begin
            slow_run_r <= slow_run;
            slow_prev_r <= slow_lvl;
            if (slow_run) begin
                slow_acc_r <= slow_acc_r
                    + occ_trim_inc(occ_pkg::SLOW_INC, occ_pkg::SLOW_STEP, slow_trim_r);
            end else begin
                slow_acc_r <= 32'h0000_0000;
            end
        end
    end

    // postscaler, bit k gives 8 MHz over 2^(k+1)
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            post_r <= '0;
        end else if (fast_rise) begin
            post_r <= post_r + 6'h01;
        end
    end

    // trim settling, fast one step per interval
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            slow_trim_r <= occ_pkg::TRIM_RST;
            fast_trim_r <= occ_pkg::TRIM_RST;
            step_cnt_r <= '0;
        end else begin
            if (slow_fall || !slow_run) begin
                slow_trim_r <= trim_r;
            end
            if (step_cnt_r == STEP_W'(occ_pkg::FAST_STEP_CYC - 1)) begin
                step_cnt_r <= '0;
                if ($signed(fast_trim_r) < $signed(trim_r)) begin
                    fast_trim_r <= fast_trim_r + 6'h01;
                end else if ($signed(fast_trim_r) > $signed(trim_r)) begin
                    fast_trim_r <= fast_trim_r - 6'h01;
                end
            end else begin
                step_cnt_r <= step_cnt_r + STEP_W'(1);
            end
        end
    end

    // current and requested clock levels
    always_comb begin
        cur_lvl = occ_sel_level(cur_sel_r, fast_lvl, post_r, slow_lvl);
        req_lvl = occ_sel_level(sel_r, fast_lvl, post_r, slow_lvl);
        cur_fall = cur_prev_r && !cur_lvl;
        req_fall = req_prev_r && !req_lvl && !sel_chg_r;
    end

    // previous levels
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_prev_r <= 1'b0;
            req_prev_r <= 1'b0;
        end else begin
            cur_prev_r <= cur_lvl;
            req_prev_r <= req_lvl;
        end
    end

    // glitch-free clock switch sequencer
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sw_state_r <= occ_pkg::OCC_SW_IDLE;
            cur_sel_r <= occ_pkg::SEL_SLOW;
            edge_cnt_r <= 4'h0;
            int_clk_r <= 1'b0;
        end else begin
            case (sw_state_r)
                occ_pkg::OCC_SW_IDLE: begin
                    int_clk_r <= cur_lvl;
                    if (sel_r != cur_sel_r) begin
                        sw_state_r <= occ_pkg::OCC_SW_WAIT_CUR;
                    end
                end
                occ_pkg::OCC_SW_WAIT_CUR: begin
                    int_clk_r <= cur_lvl;
                    if (cur_fall) begin
                        int_clk_r <= 1'b0;
                        edge_cnt_r <= 4'h0;
                        sw_state_r <= occ_pkg::OCC_SW_COUNT_REQ;
                    end
                end
                occ_pkg::OCC_SW_COUNT_REQ: begin
                    int_clk_r <= 1'b0;
                    if (sel_chg_r) begin
                        edge_cnt_r <= 4'h0;
                    end else if (req_fall) begin
                        if (edge_cnt_r == occ_pkg::SWITCH_EDGES - 4'h1) begin
                            cur_sel_r <= sel_r;
                            sw_state_r <= occ_pkg::OCC_SW_IDLE;
                        end else begin
                            edge_cnt_r <= edge_cnt_r + 4'h1;
                        end
                    end
                end
                default: begin
                    sw_state_r <= occ_pkg::OCC_SW_IDLE;
                end
            endcase
        end
    end

    // stable flag and switch delay
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            stable_r <= 1'b0;
            pend_r <= 1'b0;
            dly_r <= '0;
        end else if (sel_start) begin
            stable_r <= 1'b0;
            pend_r <= 1'b1;
            dly_r <= DLY_W'(SWITCH_DLY_CYC);
        end else begin
            if (dly_r != '0) begin
                dly_r <= dly_r - DLY_W'(1);
            end
            if (pend_r && dly_r == '0 && sw_state_r == occ_pkg::OCC_SW_IDLE) begin
                stable_r <= 1'b1;
                pend_r <= 1'b0;
            end
        end
    end

    // system clock source by mode
    always_comb begin
        sys_lvl = occ_is_internal(mode_r) ? int_clk_r : cin_s2_r;
        sys_fall = sys_prev_r && !sys_lvl;
        sys_rise = !sys_prev_r && sys_lvl;
    end

    // clock level, tick and divider
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sys_prev_r <= 1'b0;
            sys_lvl_r <= 1'b0;
            tick_r <= 1'b0;
            div_r <= '0;
        end else begin
            sys_prev_r <= sys_lvl;
            sys_lvl_r <= sys_lvl;
            tick_r <= sys_rise && osc_ready_r && !sleep_req;
            if (sys_fall && !sleep_req) begin
                div_r <= div_r + 2'h1;
            end
        end
    end

    // oscillator pin use by mode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cout_o_r <= 1'b0;
            cout_oe_r <= 1'b0;
            cin_o_r <= 1'b0;
            cin_oe_r <= 1'b0;
            rd6_r <= 1'b0;
            rd7_r <= 1'b0;
        end else begin
            if (mode_r == occ_pkg::MODE_RC || mode_r == occ_pkg::MODE_INT_CLKOUT) begin
                cout_o_r <= div_r[1];
                cout_oe_r <= 1'b1;
            end else if (occ_bit6_gpio(mode_r)) begin
                cout_o_r <= port_a_bit6_lat;
                cout_oe_r <= !port_a_bit6_dir_in;
            end else begin
                cout_o_r <= 1'b0;
                cout_oe_r <= 1'b0;
            end
            if (occ_is_internal(mode_r)) begin
                cin_o_r <= port_a_bit7_lat;
                cin_oe_r <= !port_a_bit7_dir_in;
            end else begin
                cin_o_r <= 1'b0;
                cin_oe_r <= 1'b0;
            end
            rd6_r <= occ_bit6_gpio(mode_r) && cout_s2_r;
            rd7_r <= occ_is_internal(mode_r) && cin_s2_r;
        end
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign clock_in_pin_o = cin_o_r;
    assign clock_in_pin_oe = cin_oe_r;
    assign clock_out_pin_o = cout_o_r;
    assign clock_out_pin_oe = cout_oe_r;
    assign port_a_bit6_rd = rd6_r;
    assign port_a_bit7_rd = rd7_r;
    assign sys_clk_level = sys_lvl_r;
    assign sys_clk_tick = tick_r;
    assign osc_ready = osc_ready_r;
    assign slow_src_run = slow_run_r;

endmodule : occ_clock_ctrl

`default_nettype wire

// ### core/occ_pkg.sv
// constants and types for the clock control block
package occ_pkg;

    // system clock rate
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_MHZ = CLK_HZ / 1_000_000;

    // register map, printed offsets
    localparam logic [7:0] OFS_CTRL = 8'h8F;
    localparam logic [7:0] OFS_TRIM = 8'h90;

    // clock control register fields
    localparam int SEL_LSB = 4;
    localparam int SEL_W = 3;
    localparam int STABLE_BIT = 2;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // frequency trim register fields
    localparam int TRIM_W = 6;
    localparam logic [5:0] TRIM_RST = 6'h00;

    // frequency select codes
    localparam logic [2:0] SEL_SLOW = 3'h0;
    localparam logic [2:0] SEL_FAST = 3'h7;

    // oscillator pin mode codes
    localparam logic [2:0] MODE_LOW_POWER_XTAL = 3'h0;
    localparam logic [2:0] MODE_XTAL = 3'h1;
    localparam logic [2:0] MODE_HIGH_SPEED_XTAL = 3'h2;
    localparam logic [2:0] MODE_RC = 3'h3;
    localparam logic [2:0] MODE_RC_GPIO = 3'h4;
    localparam logic [2:0] MODE_INT_CLKOUT = 3'h5;
    localparam logic [2:0] MODE_INT_TWO_GPIO = 3'h6;
    localparam logic [2:0] MODE_EXT_CLOCK_GPIO = 3'h7;

    // internal sources as phase accumulators
    localparam int NCO_W = 32;
    localparam longint FAST_HZ = 8_000_000;
    localparam longint SLOW_HZ = 31_250;
    localparam logic [31:0] FAST_INC = 32'((FAST_HZ << NCO_W) / longint'(CLK_HZ));
    localparam logic [31:0] SLOW_INC = 32'((SLOW_HZ << NCO_W) / longint'(CLK_HZ));

    // trim span of one eighth over 32 steps each way
    localparam int TRIM_SPAN_DIV = 8;
    localparam int TRIM_STEPS = 32;
    localparam logic [31:0] FAST_STEP = FAST_INC / 32'(TRIM_SPAN_DIV * TRIM_STEPS);
    localparam logic [31:0] SLOW_STEP = SLOW_INC / 32'(TRIM_SPAN_DIV * TRIM_STEPS);

    // postscaler stages below the fast source
    localparam int POST_W = 6;

    // requested clock edges before switch-over
    localparam logic [3:0] SWITCH_EDGES = 4'h8;

    // delay after leaving the slow source
    localparam int SWITCH_DLY_US = 4000;
    localparam int SWITCH_DLY_CYC = SWITCH_DLY_US * CLK_MHZ;

    // fast source trim settling
    localparam int FAST_SETTLE_US = 1000;
    localparam int TRIM_LEVELS = 64;
    localparam int FAST_SETTLE_CYC = FAST_SETTLE_US * CLK_MHZ;
    localparam int FAST_STEP_CYC = FAST_SETTLE_CYC / TRIM_LEVELS;
    localparam int FAST_STEP_W = 11;

    // clock output divide by four
    localparam int FOSC_DIV_W = 2;

    // switch sequencer states
    typedef enum logic [1:0] {
        OCC_SW_IDLE,
        OCC_SW_WAIT_CUR,
        OCC_SW_COUNT_REQ
    } occ_sw_state_t;

endpackage : occ_pkg

// ### tb/occ_clock_ctrl_chk.sv
// port assertions for the clock control block
`timescale 1ns/1ps
`default_nettype none
module occ_clock_ctrl_chk #(
    parameter int SWITCH_DLY_CYC = 50  // switch delay in cycles
) (
    input wire logic sys_clk,             // clock
    input wire logic rstn,                // reset, active low
    input wire logic [7:0] reg_addr,      // address
    input wire logic [7:0] reg_wdata,     // write data
    input wire logic reg_we,              // write strobe
    input wire logic reg_re,              // read strobe
    input wire logic [7:0] reg_rdata,     // read data
    input wire logic [2:0] osc_mode_cfg,  // pin mode
    input wire logic pwrt_en,             // power-up timer on
    input wire logic wdt_en,              // watchdog on
    input wire logic port_a_bit6_lat,     // latch bit 6
    input wire logic port_a_bit6_dir_in,  // bit 6 is input
    input wire logic clock_out_pin_o,     // out pin value
    input wire logic clock_out_pin_oe,    // out pin driven
    input wire logic sys_clk_tick,        // clock rise pulse
    input wire logic osc_ready,           // oscillator usable
    input wire logic slow_src_run         // slow source on
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    logic [1:0] cnt_r;
    logic [2:0] sel_r;
    int dly_r;
    wire logic rd_ctl = reg_re && reg_addr == occ_pkg::OFS_CTRL;
    wire logic wr_ctl = reg_we && reg_addr == occ_pkg::OFS_CTRL;
    wire logic gp6 = osc_mode_cfg inside {3'h4, 3'h6, 3'h7};
    // edges since reset release, saturating
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) cnt_r <= 2'h0;
        else if (cnt_r != 2'h3) cnt_r <= cnt_r + 2'h1;
    end
    // select shadow and delay count
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            sel_r <= 3'h0;
            dly_r <= SWITCH_DLY_CYC;
        end else begin
            if (wr_ctl) sel_r <= reg_wdata[6:4];
            if (wr_ctl && sel_r == 3'h0 && reg_wdata[6:4] != 3'h0) dly_r <= 0;
            else if (dly_r < SWITCH_DLY_CYC) dly_r <= dly_r + 1;
        end
    end
    AST_RD_IDLE: assert property (!$past(reg_re) |-> reg_rdata == 8'h00)
        else $error("read data not idle");
    AST_TRIM_HI: assert property ($past(reg_re && reg_addr == occ_pkg::OFS_TRIM)
        |-> reg_rdata[7:6] == 2'h0) else $error("trim upper bits set");
    AST_CTL_RO: assert property ($past(rd_ctl) |-> {reg_rdata[7], reg_rdata[3],
        reg_rdata[1:0]} == 4'h0) else $error("control reserved bits set");
    AST_SEL_RB: assert property ($past(rd_ctl) |-> reg_rdata[6:4] == $past(sel_r))
        else $error("select readback wrong");
    AST_STAB_LOW: assert property ($past(rd_ctl && dly_r < SWITCH_DLY_CYC - 1)
        |-> !reg_rdata[2]) else $error("stable set too early");
    AST_READY: assert property (cnt_r == 2'h3 |-> osc_ready)
        else $error("oscillator not ready");
    AST_SLOW: assert property (cnt_r == 2'h3 && $past(pwrt_en || wdt_en) |-> slow_src_run)
        else $error("slow source stopped");
    AST_CLOCK_OUTPUT_OE: assert property (cnt_r == 2'h3 && osc_mode_cfg inside {3'h3, 3'h5}
        |-> clock_out_pin_oe) else $error("clock out not driven");
    AST_GP6: assert property (cnt_r == 2'h3 && gp6 |-> clock_out_pin_oe == !$past(
        port_a_bit6_dir_in) && (!clock_out_pin_oe || clock_out_pin_o == $past(port_a_bit6_lat)))
        else $error("bit 6 drive wrong");
    AST_TICK: assert property (sys_clk_tick |=> !sys_clk_tick)
        else $error("tick longer than one cycle");
    cover property (wr_ctl && sel_r == 3'h0 && reg_wdata[6:4] != 3'h0);
    cover property ($past(rd_ctl) && reg_rdata[2]);
    cover property (gp6 && clock_out_pin_oe);
endmodule : occ_clock_ctrl_chk
bind occ_clock_ctrl occ_clock_ctrl_chk #(.SWITCH_DLY_CYC(SWITCH_DLY_CYC)) occ_clock_ctrl_chk_i (.*);
`default_nettype wire

// ### tb/occ_ext_src.sv
// external clock source on the clock in pin
`timescale 1ns/1ps
`default_nettype none
module occ_ext_src #(
    parameter int HALF = 20  // half period in bench cycles
) (
    input wire logic sys_clk,  // bench clock
    input wire logic en,       // source connected
    output logic lvl           // level offered on the pin
);
    int cnt = 0;
    initial lvl = 1'b0;
    // free-running clock, changing junk when disconnected
    always @(posedge sys_clk) begin
        cnt <= (cnt + 1) % HALF;
        if (!en || cnt == 0) lvl <= ~lvl;
    end
endmodule : occ_ext_src
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int DLY = 50;
    localparam logic [7:0] CT = occ_pkg::OFS_CTRL;
    localparam logic [7:0] TR = occ_pkg::OFS_TRIM;
    logic sys_clk = 1'b0, rstn = 1'b0, reg_we = 1'b0, reg_re = 1'b0, pwrt_en = 1'b0;
    logic wdt_en = 1'b0, sleep_req = 1'b0, port_a_bit6_lat = 1'b0, port_a_bit6_dir_in = 1'b1;
    logic port_a_bit7_lat = 1'b0, port_a_bit7_dir_in = 1'b1, g6 = 1'b0, g7 = 1'b0;
    logic pv = 1'b0, rnd_en = 1'b0, arm = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd_v;
    logic [2:0] osc_mode_cfg = 3'h5;
    logic [2:0] modes [4] = '{3'h3, 3'h4, 3'h6, 3'h7};
    wire logic [7:0] reg_rdata;
    wire logic clock_in_pin_o, clock_in_pin_oe, clock_out_pin_o, clock_out_pin_oe, ext;
    wire logic port_a_bit6_rd, port_a_bit7_rd, sys_clk_level, sys_clk_tick, osc_ready, slow_src_run;
    int bad_count = 0, n_checks = 0, seed = 32'h6f36, ph = 0, ticks, outs, i, c;
    wire logic ext_on = osc_mode_cfg inside {3'h3, 3'h4, 3'h7};
    wire logic gp6 = osc_mode_cfg inside {3'h4, 3'h6, 3'h7};
    wire logic gp7 = osc_mode_cfg inside {3'h5, 3'h6};
    wire logic clock_in_pin_i = clock_in_pin_oe ? clock_in_pin_o : (ext_on ? ext : g7);
    wire logic clock_out_pin_i = clock_out_pin_oe ? clock_out_pin_o : g6;
    always #4 sys_clk = ~sys_clk;
    occ_ext_src occ_ext_src_i (.sys_clk(sys_clk), .en(ext_on), .lvl(ext));
    occ_clock_ctrl #(.SWITCH_DLY_CYC(DLY)) occ_clock_ctrl_i (.*);
    function automatic logic [7:0] near(input int a, input int e, input int tol);
        return 8'(a >= e - tol && a <= e + tol);
    endfunction : near
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_we <= 1'b1;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_re <= 1'b1;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic reset(input logic [2:0] m);
        rnd_en <= 1'b0;
        rstn <= 1'b0;
        osc_mode_cfg <= m;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (9) @(posedge sys_clk);
        rnd_en <= 1'b1;
    endtask : reset
    task automatic measure(input int n);
        ticks = 0;
        outs = 0;
        repeat (n) begin
            @(posedge sys_clk);
            ticks += int'(sys_clk_tick);
            outs += int'(clock_out_pin_o & ~pv);
            pv = clock_out_pin_o;
        end
    endtask : measure
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : print_verdict
    // random pin stimulus, latches change each cycle, the rest held eight cycles
    always @(posedge sys_clk) begin
        ph <= (ph + 1) % 8;
        port_a_bit6_lat <= 1'($random(seed));
        port_a_bit7_lat <= 1'($random(seed));
        if (ph == 0) begin
            arm <= rnd_en;
            port_a_bit6_dir_in <= 1'($random(seed));
            port_a_bit7_dir_in <= 1'($random(seed));
            g6 <= 1'($random(seed));
            g7 <= 1'($random(seed));
            pwrt_en <= 1'($random(seed));
            wdt_en <= 1'($random(seed));
        end
        if (ph == 7 && arm && rnd_en && gp6 && port_a_bit6_dir_in)
            chk(8'(port_a_bit6_rd), 8'(g6));
        if (ph == 7 && arm && rnd_en && gp7 && port_a_bit7_dir_in)
            chk(8'(port_a_bit7_rd), 8'(g7));
    end
    // hang guard
    initial begin
        #(8 * 95000);
        bad_count++;
        print_verdict();
    end
    // main scenario sequence
    initial begin
        reset(3'h5);
        rd(CT, rd_v);
        chk(rd_v, 8'h00);
        wr(TR, 8'hFF);
        rd(TR, rd_v);
        chk(rd_v, 8'h3F);
        wr(8'h91, 8'h55);
        rd(8'h91, rd_v);
        chk(rd_v, 8'h00);
        wr(TR, 8'h00);
        wr(CT, 8'hFF);
        rd(CT, rd_v);
        chk(rd_v, 8'h70);
        for (i = 0; i < 4000 && rd_v[2] !== 1'b1; i++) rd(CT, rd_v);
        chk(8'(rd_v[2]), 8'h01);
        for (c = 7; c >= 1; c--) begin
            wr(CT, 8'(c << 4));
            repeat (160 << (7 - c)) @(posedge sys_clk);
            rd(CT, rd_v);
            chk(rd_v, 8'(c << 4) | 8'h04);
            measure(4000);
            chk(near(ticks, 256 >> (7 - c), 1), 8'h01);
            chk(near(outs * 4, ticks, 4), 8'h01);
        end
        wr(CT, 8'h00);
        rd(CT, rd_v);
        chk(rd_v, 8'h04);
        chk(8'(slow_src_run), 8'h01);
        wr(CT, 8'h10);
        rd(CT, rd_v);
        chk(rd_v, 8'h10);
        foreach (modes[k]) begin
            reset(modes[k]);
            measure(1600);
            if (ext_on) chk(near(ticks, 40, 2), 8'h01);
            if (modes[k] == 3'h3) chk(near(outs * 4, ticks, 4), 8'h01);
            chk(8'(osc_ready), 8'h01);
        end
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
